// [bench/occ_load.sv]
// Far-side load on the compare output pin: counts the edges it sees.
// Assumes the pin is sampled on the core clock like any synchronous input.
`timescale 1ns/1ps
`default_nettype none
module occ_load (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output int rises,
    output int falls
);
    // ==========================================================
    // Edge counters
    logic last_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_q <= 1'b0;
            rises <= 0;
            falls <= 0;
        end else begin
            last_q <= pin;
            // A passive load never drives back, so no other rule to keep here
            if (pin && !last_q) begin
                rises <= rises + 1;
            end
            if (!pin && last_q) begin
                falls <= falls + 1;
            end
        end
    end
endmodule
`default_nettype wire

// [bench/tb_occ_channel.sv]
// Self-checking bench of the output compare channel over its Wishbone port.
// Assumes the time bases are held still around every control write.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("ERROR %0t got %h exp %h", $time, got, exp); end end
module tb_occ_channel;
    import occ_pkg::*;
    // ==========================================================
    // Signals
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pin, irq;
    logic idle = 1'b0, gpio = 1'b0, fault = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic [15:0] tb1 = 16'h0000, tb2 = 16'h0000;
    int n_mismatch = 0, samples_checked = 0, cycles = 0, rises, falls, r0, f0;
    always #5 clk = ~clk;
    occ_channel occ_channel_inst (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .TIME_BASE_FIRST(tb1), .TIME_BASE_SECOND(tb2), .CPU_IDLE(idle),
        .GPIO_LEVEL(gpio), .SHARED_FAULT_INPUT(fault), .COMPARE_OUT_PIN(pin), .IRQ(irq));
    occ_load occ_load_inst (.clk(clk), .rst(rst), .pin(pin), .rises(rises), .falls(falls));
    // ==========================================================
    // Bus and stimulus tasks
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        if (ack !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t no bus answer", $time);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    // Bases stay still here: reconfiguring under a moving timer is not allowed
    task automatic cfg(input logic [15:0] c, input logic [15:0] p, input logic [15:0] s);
        wr(OCC_ADR_PRIMARY, {16'h0, p});
        wr(OCC_ADR_SECONDARY, {16'h0, s});
        wr(OCC_ADR_CTRL, {16'h0, c});
        wr(OCC_ADR_INT_STAT, 32'h3);
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Moves one time base, then lets the match edge and its update land
    task automatic tick(input logic s, input logic [15:0] v);
        @(posedge clk);
        if (s) begin
            tb2 <= v;
        end else begin
            tb1 <= v;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pchk(input logic p, input logic i);
        `CHK({pin, irq}, {p, i})
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_mismatch++;
            results();
        end
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(OCC_ADR_CTRL, 32'h0);
        rd(OCC_ADR_PRIMARY, 32'h0);
        rd(OCC_ADR_INT_MASK, 32'h0);
        rd(8'h14, 32'h0);
        tick(0, 16'h0000);
        @(posedge clk) gpio <= 1'b1;
        tick(0, 16'h0000);
        pchk(1'b1, 1'b0);
        @(posedge clk) gpio <= 1'b0;
        tick(0, 16'h0000);
        pchk(1'b0, 1'b0);
        $display("test reset and disabled done");
        wr(OCC_ADR_INT_MASK, 32'h3);
        rd(OCC_ADR_INT_MASK, 32'h3);
        cfg(16'h0001, 16'h0005, 16'h0000);
        pchk(1'b0, 1'b0);
        tick(0, 16'h0005);
        pchk(1'b1, 1'b1);
        rd(OCC_ADR_INT_STAT, 32'h1);
        cfg(16'h2001, 16'h0005, 16'h0000);
        @(posedge clk) idle <= 1'b1;
        tick(0, 16'h0009);
        tick(0, 16'h0005);
        pchk(1'b0, 1'b0);
        @(posedge clk) idle <= 1'b0;
        tick(0, 16'h0009);
        tick(0, 16'h0005);
        pchk(1'b1, 1'b1);
        $display("test low one-shot and idle done");
        @(posedge clk) idle <= 1'b1;
        cfg(16'h000a, 16'h0033, 16'h0000);
        pchk(1'b1, 1'b0);
        tick(0, 16'h0033);
        pchk(1'b1, 1'b0);
        tick(1, 16'h0033);
        pchk(1'b0, 1'b1);
        @(posedge clk) idle <= 1'b0;
        cfg(16'h0003, 16'h0020, 16'h0000);
        pchk(1'b0, 1'b0);
        tick(0, 16'h0020);
        pchk(1'b1, 1'b1);
        wr(OCC_ADR_INT_STAT, 32'h1);
        tick(0, 16'h0021);
        tick(0, 16'h0020);
        pchk(1'b0, 1'b1);
        $display("test high one-shot and toggle done");
        wr(OCC_ADR_INT_MASK, 32'h0);
        cfg(16'h0004, 16'h0003, 16'h0007);
        pchk(1'b0, 1'b0);
        tick(0, 16'h0003);
        pchk(1'b1, 1'b0);
        tick(0, 16'h0007);
        pchk(1'b0, 1'b0);
        rd(OCC_ADR_INT_STAT, 32'h1);
        wr(OCC_ADR_INT_MASK, 32'h3);
        #1;
        pchk(1'b0, 1'b1);
        tick(0, 16'h0003);
        pchk(1'b0, 1'b1);
        cfg(16'h0005, 16'h0003, 16'h0007);
        tick(0, 16'h0000);
        r0 = rises;
        f0 = falls;
        for (int k = 0; k < 2; k++) begin
            tick(0, 16'h0003);
            pchk(1'b1, 1'b0);
            tick(0, 16'h0007);
            pchk(1'b0, 1'b1);
            wr(OCC_ADR_INT_STAT, 32'h1);
        end
        `CHK(rises - r0, 2)
        `CHK(falls - f0, 2)
        $display("test pulse modes done");
        cfg(16'h0006, 16'h0005, 16'h0000);
        pchk(1'b1, 1'b0);
        @(posedge clk) fault <= 1'b0;
        tick(0, 16'h0001);
        repeat (6) @(posedge clk);
        #1;
        pchk(1'b1, 1'b0);
        tick(0, 16'h0005);
        pchk(1'b0, 1'b0);
        tick(0, 16'h0000);
        pchk(1'b1, 1'b0);
        @(posedge clk) fault <= 1'b1;
        cfg(16'h0007, 16'h0000, 16'h0000);
        pchk(1'b0, 1'b0);
        cfg(16'h0007, 16'h0005, 16'h0000);
        pchk(1'b1, 1'b0);
        @(posedge clk) fault <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        pchk(1'b0, 1'b1);
        rd(OCC_ADR_CTRL, 32'h17);
        rd(OCC_ADR_INT_STAT, 32'h2);
        // Period start must not lift the pin while the fault is latched
        tick(0, 16'h0001);
        tick(0, 16'h0000);
        pchk(1'b0, 1'b1);
        wr(OCC_ADR_CTRL, 32'h10);
        rd(OCC_ADR_CTRL, 32'h0);
        @(posedge clk) fault <= 1'b1;
        repeat (4) @(posedge clk);
        cfg(16'h0007, 16'h0005, 16'h0000);
        rd(OCC_ADR_CTRL, 32'h7);
        pchk(1'b1, 1'b0);
        $display("test pwm and fault done");
        wr(OCC_ADR_CTRL, 32'hffff);
        rd(OCC_ADR_CTRL, 32'h200f);
        $display("test control readback done");
        results();
    end
endmodule
`default_nettype wire

// [hdl/occ_channel.sv]
// Output compare channel: compares a selected time base against two values.
// Assumes both time bases and the idle and port-logic levels come from the core clock.
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module occ_channel
    import occ_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [15:0] TIME_BASE_FIRST,
    input wire logic [15:0] TIME_BASE_SECOND,
    input wire logic CPU_IDLE,
    input wire logic GPIO_LEVEL,
    input wire logic SHARED_FAULT_INPUT,
    output logic COMPARE_OUT_PIN,
    output logic IRQ
);
    // ==========================================================
    // Helpers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wdat,
                                            input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wdat[15:8];
        end
        return res;
    endfunction

    function automatic logic init_level(input logic [2:0] mode, input logic cur,
                                        input logic gpio, input logic [15:0] primary);
        logic lvl;
        lvl = 1'b0;
        case (mode)
            MODE_OFF: lvl = gpio;
            MODE_ONE_HIGH: lvl = 1'b1;
            MODE_TOGGLE: lvl = cur;
            MODE_PWM_FREE, MODE_PWM_FLT: lvl = (primary != TIMER_ZERO);
            default: lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    // ==========================================================
    // Declarations
    occ_ctrl_type ctrl_q;
    occ_ctrl_type ctrl_new;
    occ_pulse_type pulse_q, pulse_d;
    logic ack_q;
    logic [31:0] dat_q;
    logic [15:0] primary_q, secondary_q, timer_prev_q, tb, ctrl_rd, ctrl_wval;
    logic [INT_W-1:0] int_stat_q, int_mask_q, int_set;
    logic fault_q, pin_q, pin_d, cmp_evt, flt_evt;
    logic flt_s1_q, flt_s2_q, flt_s3_q, flt_fall;
    logic bus_req, bus_wr, ctrl_wr, run, fresh, hit_p, hit_s, period_start;

    // ==========================================================
    // Wishbone slave: registered ack, one wait state, unmapped reads zero
    assign bus_req = WB_CYC_I && WB_STB_I;
    assign bus_wr = bus_req && WB_WE_I && ack_q;
    // Reconfiguration is safe only because software holds the timer still
    assign ctrl_wr = bus_wr && (WB_ADR_I == OCC_ADR_CTRL) && WB_SEL_I[0];
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req && !ack_q;
        end
    end

    always_comb begin
        ctrl_rd = 16'h0000;
        ctrl_rd[CTRL_MODE_MSB:CTRL_MODE_LSB] = ctrl_q.compare_mode_sel;
        ctrl_rd[CTRL_TSEL_BIT] = ctrl_q.time_base_sel;
        ctrl_rd[CTRL_FLT_BIT] = fault_q;
        ctrl_rd[CTRL_SIDL_BIT] = ctrl_q.stop_in_idle;
        ctrl_wval = merge16(ctrl_rd, WB_DAT_I, WB_SEL_I);
        ctrl_new.compare_mode_sel = ctrl_wval[CTRL_MODE_MSB:CTRL_MODE_LSB];
        ctrl_new.time_base_sel = ctrl_wval[CTRL_TSEL_BIT];
        ctrl_new.stop_in_idle = ctrl_wval[CTRL_SIDL_BIT];
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            dat_q <= RD_ZERO;
        end else if (bus_req && !ack_q) begin
            case (WB_ADR_I)
                OCC_ADR_CTRL: dat_q <= {16'h0000, ctrl_rd};
                OCC_ADR_PRIMARY: dat_q <= {16'h0000, primary_q};
                OCC_ADR_SECONDARY: dat_q <= {16'h0000, secondary_q};
                OCC_ADR_INT_STAT: dat_q <= {30'h0000_0000, int_stat_q};
                OCC_ADR_INT_MASK: dat_q <= {30'h0000_0000, int_mask_q};
                default: dat_q <= RD_ZERO;
            endcase
        end else begin
            dat_q <= RD_ZERO;
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= CTRL_RESET;
        end else if (bus_wr && (WB_ADR_I == OCC_ADR_CTRL)) begin
            ctrl_q <= ctrl_new;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            primary_q <= CMP_RESET;
            secondary_q <= CMP_RESET;
        end else if (bus_wr) begin
            if (WB_ADR_I == OCC_ADR_PRIMARY) begin
                primary_q <= merge16(primary_q, WB_DAT_I, WB_SEL_I);
            end
            if (WB_ADR_I == OCC_ADR_SECONDARY) begin
                secondary_q <= merge16(secondary_q, WB_DAT_I, WB_SEL_I);
            end
        end
    end

    // ==========================================================
    // Fault pin synchroniser; only the second and third stages are looked at
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            flt_s1_q <= 1'b1;
            flt_s2_q <= 1'b1;
            flt_s3_q <= 1'b1;
        end else begin
            flt_s1_q <= SHARED_FAULT_INPUT;
            flt_s2_q <= flt_s1_q;
            flt_s3_q <= flt_s2_q;
        end
    end
    assign flt_fall = flt_s3_q && !flt_s2_q;

    // ==========================================================
    // Compare: a match fires once, when the time base arrives at the value
    assign tb = ctrl_q.time_base_sel ? TIME_BASE_SECOND : TIME_BASE_FIRST;
    assign run = !(ctrl_q.stop_in_idle && CPU_IDLE);
    assign fresh = (tb != timer_prev_q);
    assign hit_p = run && fresh && (tb == primary_q);
    assign hit_s = run && fresh && (tb == secondary_q);
    assign period_start = run && fresh && (tb == TIMER_ZERO);

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            timer_prev_q <= TIMER_ZERO;
        end else begin
            timer_prev_q <= tb;
        end
    end

    // ==========================================================
    // Mode behaviour
    always_comb begin
        pin_d = pin_q;
        pulse_d = pulse_q;
        cmp_evt = 1'b0;
        flt_evt = 1'b0;
        case (ctrl_q.compare_mode_sel)
            MODE_OFF: pin_d = GPIO_LEVEL;
            MODE_ONE_LOW: begin
                if (hit_p && pulse_q == PULSE_ARMED) begin
                    pin_d = 1'b1;
                    cmp_evt = !pin_q;
                    pulse_d = PULSE_DONE;
                end
            end
            MODE_ONE_HIGH: begin
                if (hit_p && pulse_q == PULSE_ARMED) begin
                    pin_d = 1'b0;
                    cmp_evt = pin_q;
                    pulse_d = PULSE_DONE;
                end
            end
            MODE_TOGGLE: begin
                if (hit_p) begin
                    pin_d = !pin_q;
                    cmp_evt = 1'b1;
                end
            end
            MODE_DELAYED, MODE_CONT: begin
                case (pulse_q)
                    PULSE_ARMED: begin
                        if (hit_p) begin
                            pin_d = 1'b1;
                            pulse_d = PULSE_ACTIVE;
                        end
                    end
                    PULSE_ACTIVE: begin
                        if (hit_s) begin
                            pin_d = 1'b0;
                            cmp_evt = 1'b1;
                            pulse_d = (ctrl_q.compare_mode_sel == MODE_DELAYED) ?
                                      PULSE_DONE : PULSE_ARMED;
                        end
                    end
                    default: pulse_d = pulse_q;
                endcase
            end
            MODE_PWM_FREE, MODE_PWM_FLT: begin
                // Primary is the duty; a zero duty keeps the pin low
                if (hit_p) begin
                    pin_d = 1'b0;
                end else if (period_start) begin
                    pin_d = (primary_q != TIMER_ZERO);
                end
                if (ctrl_q.compare_mode_sel == MODE_PWM_FLT) begin
                    if (run && flt_fall) begin
                        flt_evt = 1'b1;
                    end
                    if (fault_q || flt_evt) begin
                        pin_d = 1'b0;
                    end
                end
            end
            default: pin_d = pin_q;
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pin_q <= 1'b0;
            pulse_q <= PULSE_ARMED;
        end else if (ctrl_wr) begin
            pin_q <= init_level(ctrl_new.compare_mode_sel, pin_q, GPIO_LEVEL, primary_q);
            pulse_q <= PULSE_ARMED;
        end else begin
            pin_q <= pin_d;
            pulse_q <= pulse_d;
        end
    end
    assign COMPARE_OUT_PIN = pin_q;

    // Rewriting the mode is the hardware's cue to clear; a new fault wins
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            fault_q <= 1'b0;
        end else if (flt_evt) begin
            fault_q <= 1'b1;
        end else if (ctrl_wr) begin
            fault_q <= 1'b0;
        end
    end

    // ==========================================================
    // Interrupt status and mask
    always_comb begin
        int_set = INT_RESET;
        int_set[INT_CMP_BIT] = cmp_evt;
        int_set[INT_FLT_BIT] = flt_evt;
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            int_stat_q <= INT_RESET;
        end else if (bus_wr && (WB_ADR_I == OCC_ADR_INT_STAT) && WB_SEL_I[0]) begin
            int_stat_q <= (int_stat_q & ~WB_DAT_I[INT_W-1:0]) | int_set;
        end else begin
            int_stat_q <= int_stat_q | int_set;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            int_mask_q <= INT_RESET;
        end else if (bus_wr && (WB_ADR_I == OCC_ADR_INT_MASK) && WB_SEL_I[0]) begin
            int_mask_q <= WB_DAT_I[INT_W-1:0];
        end
    end
    assign IRQ = |(int_stat_q & int_mask_q);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_fault_hit;
        ctrl_q.compare_mode_sel == MODE_PWM_FLT && run && flt_fall && !ctrl_wr;
    endsequence
    sequence s_fault_held;
        fault_q && !pin_q && int_stat_q[INT_FLT_BIT];
    endsequence

    a_off_no_int: assert property (
        ctrl_q.compare_mode_sel == MODE_OFF && !ctrl_wr
        |=> pin_q == $past(GPIO_LEVEL) && !$past(cmp_evt) && !$past(flt_evt)
    ) else $error("disabled channel drives pin or raises event");
    a_one_low_rise: assert property (
        ctrl_q.compare_mode_sel == MODE_ONE_LOW && !ctrl_wr && hit_p && !pin_q
        && pulse_q == PULSE_ARMED |=> pin_q && int_stat_q[INT_CMP_BIT]
    ) else $error("active-low one-shot missed its rising edge");
    a_one_high_fall: assert property (
        ctrl_q.compare_mode_sel == MODE_ONE_HIGH && !ctrl_wr && hit_p && pin_q
        && pulse_q == PULSE_ARMED |=> !pin_q && int_stat_q[INT_CMP_BIT]
    ) else $error("active-high one-shot missed its falling edge");
    a_toggle_flip: assert property (
        ctrl_q.compare_mode_sel == MODE_TOGGLE && !ctrl_wr && hit_p
        |=> pin_q != $past(pin_q) && int_stat_q[INT_CMP_BIT]
    ) else $error("toggle mode did not invert the pin");
    a_delayed_done: assert property (
        ctrl_q.compare_mode_sel == MODE_DELAYED && !ctrl_wr && pulse_q == PULSE_ACTIVE
        && hit_s |=> !pin_q && pulse_q == PULSE_DONE ##1 (pulse_q == PULSE_DONE || $past(ctrl_wr))
    ) else $error("delayed one-shot did not end after one pulse");
    a_cont_rearm: assert property (
        ctrl_q.compare_mode_sel == MODE_CONT && !ctrl_wr && pulse_q == PULSE_ACTIVE
        && hit_s |=> !pin_q && pulse_q == PULSE_ARMED && int_stat_q[INT_CMP_BIT]
    ) else $error("continuous pulse did not re-arm");
    a_pwm_free_quiet: assert property (
        ctrl_q.compare_mode_sel == MODE_PWM_FREE
        |-> !cmp_evt && !flt_evt && (!$rose(fault_q) || $past(ctrl_wr))
    ) else $error("unprotected PWM raised an event");
    a_fault_hold_low: assert property (
        s_fault_hit |=> s_fault_held
    ) else $error("fault edge not taken in protected PWM");
    a_fault_sticky: assert property (
        fault_q && !ctrl_wr |=> fault_q
    ) else $error("fault flag cleared without a mode rewrite");
    a_time_base_sel: assert property (
        hit_p |-> (ctrl_q.time_base_sel ? TIME_BASE_SECOND : TIME_BASE_FIRST) == primary_q
    ) else $error("match taken from the wrong time base");
    a_idle_halt: assert property (
        !run && !ctrl_wr && ctrl_q.compare_mode_sel != MODE_OFF
        |=> pin_q == $past(pin_q) && pulse_q == $past(pulse_q)
    ) else $error("channel moved while halted in idle");
    a_ctrl_rsvd_zero: assert property (
        ack_q && !WB_WE_I && WB_ADR_I == OCC_ADR_CTRL |-> WB_DAT_O[31:14] == 18'h00000
        && WB_DAT_O[12:5] == 8'h00
    ) else $error("unimplemented control bits read non-zero");
    a_fault_pin_low: assert property (
        fault_q && ctrl_q.compare_mode_sel == MODE_PWM_FLT && !ctrl_wr |=> !pin_q
    ) else $error("pin not held low after fault");
endmodule
`default_nettype wire

// [inc/occ_pkg.sv]
// Constants, register map and types of the output compare channel.
// Assumes a 16-bit time base source and a classic Wishbone slave port.
`default_nettype none
package occ_pkg;
    // ==========================================================
    // Register map (byte addresses, one 32-bit word each)
    localparam logic [7:0] OCC_ADR_CTRL = 8'h00;
    localparam logic [7:0] OCC_ADR_PRIMARY = 8'h04;
    localparam logic [7:0] OCC_ADR_SECONDARY = 8'h08;
    localparam logic [7:0] OCC_ADR_INT_STAT = 8'h0c;
    localparam logic [7:0] OCC_ADR_INT_MASK = 8'h10;
    // ==========================================================
    // Control and interrupt field positions
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_MODE_MSB = 2;
    localparam int unsigned CTRL_TSEL_BIT = 3;
    localparam int unsigned CTRL_FLT_BIT = 4;
    localparam int unsigned CTRL_SIDL_BIT = 13;
    localparam int unsigned INT_CMP_BIT = 0;
    localparam int unsigned INT_FLT_BIT = 1;
    localparam int unsigned INT_W = 2;
    // ==========================================================
    // Reset values
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [INT_W-1:0] INT_RESET = 2'h0;
    localparam logic [15:0] TIMER_ZERO = 16'h0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // ==========================================================
    // Mode codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_ONE_LOW = 3'h1;
    localparam logic [2:0] MODE_ONE_HIGH = 3'h2;
    localparam logic [2:0] MODE_TOGGLE = 3'h3;
    localparam logic [2:0] MODE_DELAYED = 3'h4;
    localparam logic [2:0] MODE_CONT = 3'h5;
    localparam logic [2:0] MODE_PWM_FREE = 3'h6;
    localparam logic [2:0] MODE_PWM_FLT = 3'h7;
    // ==========================================================
    // Types
    typedef struct packed {
        logic stop_in_idle;
        logic time_base_sel;
        logic [2:0] compare_mode_sel;
    } occ_ctrl_type;
    localparam occ_ctrl_type CTRL_RESET = '{1'b0, 1'b0, MODE_OFF};
    typedef enum logic [1:0] {PULSE_ARMED, PULSE_ACTIVE, PULSE_DONE} occ_pulse_type;
endpackage
`default_nettype wire
